// File: hdl/cdr_map.svh
`ifndef CDR_MAP_SVH
`define CDR_MAP_SVH
// register byte offsets
`define CDR_CTRL_OFS  8'h00
`define CDR_STAT_OFS  8'h04
`define CDR_INT_OFS   8'h08
`define CDR_MASK_OFS  8'h0C
// control fields
`define CDR_CTRL_FREQ  0
`define CDR_CTRL_SRC   1
`define CDR_CTRL_RATE  2
`define CDR_CTRL_BYP   3
`define CDR_CTRL_DLPBK 4
`define CDR_CTRL_ALPBK 5
`define CDR_CTRL_W     6
`define CDR_CTRL_RST   6'h00
// event bits, status and mask share the layout
`define CDR_EV_LOCK  0
`define CDR_EV_LOS   1
`define CDR_EV_TRACK 2
`define CDR_EV_W     3
// loss of signal detector
`define CDR_LOS_QUIET 128
`define CDR_LOS_TRANS 16
`define CDR_LOS_WIN   128
// frequency check
`define CDR_PPM      500
`define CDR_WIN_LOG2 13
`endif

// File: hdl/cdr_pkg.sv
package cdr_pkg;
    // recovery loop target
    typedef enum logic [0:0] {
        CDR_ACQ_REF = 1'b0,
        CDR_TRACK   = 1'b1
    } cdr_state_t;
endpackage

// File: hdl/cdr_los_det.sv
`timescale 1ns/1ps
`include "cdr_map.svh"
module cdr_los_det (
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic bit_strobe_i,
    input  wire logic bit_i,
    output logic      los_o
);
    import cdr_pkg::*;
    logic                      prev_reg;
    logic [7:0]                quiet_reg;
    logic [`CDR_LOS_WIN-1:0]   hist_reg;
    logic [7:0]                tcnt_reg;
    logic                      edge_w;
    logic [7:0]                tcnt_next;

    assign edge_w    = bit_strobe_i & (bit_i ^ prev_reg);
    // sliding count: add the new edge, drop the one leaving the window
    assign tcnt_next = tcnt_reg + {7'h00, edge_w} - {7'h00, hist_reg[`CDR_LOS_WIN-1]};

    // quiet run length and transition window
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prev_reg  <= 1'b0;
            quiet_reg <= 8'h00;
            hist_reg  <= '0;
            tcnt_reg  <= 8'h00;
        end else if (bit_strobe_i) begin
            prev_reg  <= bit_i;
            hist_reg  <= {hist_reg[`CDR_LOS_WIN-2:0], edge_w};
            tcnt_reg  <= tcnt_next;
            if (edge_w)
                quiet_reg <= 8'h00;
            else if (quiet_reg <= 8'(`CDR_LOS_QUIET))
                quiet_reg <= quiet_reg + 8'h01; // saturates past the limit
        end
    end

    // declare after the quiet run, clear on enough edges in the window
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            los_o <= 1'b0;
        else if (quiet_reg > 8'(`CDR_LOS_QUIET))
            los_o <= 1'b1;
        else if (bit_strobe_i && tcnt_next >= 8'(`CDR_LOS_TRANS))
            los_o <= 1'b0;
    end
endmodule

// File: hdl/cdr_freq_cmp.sv
`timescale 1ns/1ps
`include "cdr_map.svh"
module cdr_freq_cmp #(
    parameter int WIN_LOG2 = `CDR_WIN_LOG2
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       restart_i,
    input  wire logic       ref_tick_i,
    input  wire logic       rec_tick_i,
    input  wire logic [2:0] ratio_log2_i,
    output logic            done_o,
    output logic            in_range_o
);
    import cdr_pkg::*;
    localparam int CW = WIN_LOG2 + 7;
    logic [WIN_LOG2-1:0] ref_cnt_reg;
    logic [CW-1:0]       rec_cnt_reg;
    logic [CW-1:0]       rec_total;

    // expected count and deviation test against the ppm limit
    function automatic logic within_tol(input logic [CW-1:0] cnt, input logic [2:0] r);
        logic [31:0] expv;
        logic [31:0] tol;
        logic [31:0] dev;
        expv = 32'h1 << (WIN_LOG2 + int'(r));
        tol  = (expv * `CDR_PPM) / 1000000;
        dev  = ({{(32-CW){1'b0}}, cnt} > expv) ? {{(32-CW){1'b0}}, cnt} - expv
                                               : expv - {{(32-CW){1'b0}}, cnt};
        return dev <= tol;
    endfunction

    assign rec_total = rec_cnt_reg + {{(CW-1){1'b0}}, rec_tick_i};

    // gate recovered ticks by a fixed number of reference ticks
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ref_cnt_reg <= '0;
            rec_cnt_reg <= '0;
            done_o      <= 1'b0;
            in_range_o  <= 1'b0;
        end else if (restart_i) begin
            ref_cnt_reg <= '0;
            rec_cnt_reg <= '0;
            done_o      <= 1'b0;
            in_range_o  <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (ref_tick_i)
                ref_cnt_reg <= ref_cnt_reg + 1'b1;
            if (ref_tick_i && &ref_cnt_reg) begin
                rec_cnt_reg <= '0;
                done_o      <= 1'b1;
                in_range_o  <= within_tol(rec_total, ratio_log2_i);
            end else begin
                rec_cnt_reg <= rec_total;
            end
        end
    end
endmodule

// File: hdl/cdr_lock_ctrl.sv
`timescale 1ns/1ps
`include "cdr_map.svh"
module cdr_lock_ctrl (
    input  wire logic         clk_i,
    input  wire logic         rstn_i,
    // ahb-lite slave
    input  wire logic         hsel_i,
    input  wire logic [31:0]  haddr_i,
    input  wire logic [1:0]   htrans_i,
    input  wire logic         hwrite_i,
    input  wire logic [2:0]   hsize_i,
    input  wire logic [31:0]  hwdata_i,
    input  wire logic         hready_i,
    output logic [31:0]       hrdata_o,
    output logic              hreadyout_o,
    output logic              hresp_o,
    // serial side
    input  wire logic         rec_bit_strobe_i,
    input  wire logic         serial_rx_input_i,
    input  wire logic         external_recovered_clock_i,
    input  wire logic         external_signal_loss_n_i,
    input  wire logic         rec_clk_tick_i,
    input  wire logic         ref_tick_i,
    // loop and framer side
    output cdr_pkg::cdr_state_t state_o,
    output logic              ref_freq_select_o,
    output logic              recovery_ref_source_select_o,
    output logic              line_rate_select_o,
    output logic              recovery_bypass_o,
    output logic              rx_clk_from_ref_o,
    output logic [7:0]        rx_data_o,
    output logic              rx_data_valid_o,
    output logic              irq_o
);
    import cdr_pkg::*;

    logic [1:0]             rst_sync_reg;
    logic                   rst_n;
    logic                   pend_reg;
    logic                   pwrite_reg;
    logic [7:0]             paddr_reg;
    logic [`CDR_CTRL_W-1:0] ctrl_reg;
    logic [`CDR_EV_W-1:0]   int_stat_reg;
    logic [`CDR_EV_W-1:0]   int_mask_reg;
    logic [`CDR_EV_W-1:0]   int_stat_next;
    logic [`CDR_EV_W-1:0]   int_mask_next;
    logic [`CDR_EV_W-1:0]   ev_w;
    cdr_state_t             state_reg;
    cdr_state_t             state_next;
    logic [1:0]             cfg_prev_reg;
    logic                   cfg_change;
    logic                   cmp_done;
    logic                   cmp_in_range;
    logic                   los_int;
    logic                   los_prev_reg;
    logic                   loss_any;
    logic                   mute;
    logic                   xclk_prev_reg;
    logic                   bit_strobe;
    logic                   bit_val;
    logic [7:0]             shift_reg;
    logic [2:0]             bcnt_reg;
    logic                   addr_ph;
    logic                   rd_int;

    // rec/ref frequency ratio as a power of two
    function automatic logic [2:0] ratio_log2(input logic fsel, input logic src,
                                              input logic rate);
        if (src || !fsel)
            return rate ? 3'd3 : 3'd1;
        return rate ? 3'd5 : 3'd3;
    endfunction

    // reset release through two flops
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i)
            rst_sync_reg <= 2'b00;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
    assign rst_n = rst_sync_reg[1];

    // bus: every transfer takes one wait state so read data leaves a flop
    assign addr_ph = hsel_i & htrans_i[1] & hready_i;
    assign rd_int  = pend_reg & ~pwrite_reg & (paddr_reg == `CDR_INT_OFS);

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            pend_reg    <= 1'b0;
            pwrite_reg  <= 1'b0;
            paddr_reg   <= 8'h00;
            hreadyout_o <= 1'b1;
            hresp_o     <= 1'b0;
        end else begin
            hresp_o <= 1'b0; // always okay
            if (pend_reg) begin
                pend_reg    <= 1'b0;
                hreadyout_o <= 1'b1;
            end else if (addr_ph) begin
                pend_reg    <= 1'b1;
                pwrite_reg  <= hwrite_i;
                paddr_reg   <= {haddr_i[7:2], 2'b00};
                hreadyout_o <= 1'b0;
            end
        end
    end

    // read data, unmapped reads as zero
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            hrdata_o <= 32'h0000_0000;
        end else if (pend_reg && !pwrite_reg) begin
            unique case (paddr_reg)
                `CDR_CTRL_OFS: hrdata_o <= {26'h0, ctrl_reg};
                `CDR_STAT_OFS: hrdata_o <= {27'h0, cmp_in_range, loss_any,
                                            los_int, ~external_signal_loss_n_i,
                                            state_reg};
                `CDR_INT_OFS:  hrdata_o <= {29'h0, int_stat_reg};
                `CDR_MASK_OFS: hrdata_o <= {29'h0, int_mask_reg};
                default:       hrdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // control register steers the loop
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n)
            ctrl_reg <= `CDR_CTRL_RST;
        else if (pend_reg && pwrite_reg && paddr_reg == `CDR_CTRL_OFS)
            ctrl_reg <= hwdata_i[`CDR_CTRL_W-1:0];
    end

    assign int_mask_next = (pend_reg && pwrite_reg && paddr_reg == `CDR_MASK_OFS)
                         ? hwdata_i[`CDR_EV_W-1:0] : int_mask_reg;

    // a new event in the clearing read cycle survives
    assign int_stat_next = (rd_int ? '0 : int_stat_reg) | ev_w;

    // sticky status, mask and level interrupt
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            int_stat_reg <= '0;
            int_mask_reg <= '0;
            irq_o        <= 1'b0;
        end else begin
            int_stat_reg <= int_stat_next;
            int_mask_reg <= int_mask_next;
            irq_o        <= |(int_stat_next & int_mask_next);
        end
    end

    // config outputs follow the control register
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            ref_freq_select_o            <= 1'b0;
            recovery_ref_source_select_o <= 1'b0;
            line_rate_select_o           <= 1'b0;
            recovery_bypass_o            <= 1'b0;
        end else begin
            ref_freq_select_o            <= ctrl_reg[`CDR_CTRL_FREQ];
            recovery_ref_source_select_o <= ctrl_reg[`CDR_CTRL_SRC];
            line_rate_select_o           <= ctrl_reg[`CDR_CTRL_RATE];
            recovery_bypass_o            <= ctrl_reg[`CDR_CTRL_BYP];
        end
    end

    // reference change detect; aux source makes freq select don't-care
    assign cfg_change = cfg_prev_reg != {ctrl_reg[`CDR_CTRL_SRC],
                        ctrl_reg[`CDR_CTRL_FREQ] & ~ctrl_reg[`CDR_CTRL_SRC]};
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n)
            cfg_prev_reg <= 2'b00;
        else
            cfg_prev_reg <= {ctrl_reg[`CDR_CTRL_SRC],
                             ctrl_reg[`CDR_CTRL_FREQ] & ~ctrl_reg[`CDR_CTRL_SRC]};
    end

    cdr_freq_cmp u_cmp (
        .clk_i        (clk_i),
        .rst_n_i      (rst_n),
        .restart_i    (cfg_change),
        .ref_tick_i   (ref_tick_i),
        .rec_tick_i   (rec_clk_tick_i),
        .ratio_log2_i (ratio_log2(ctrl_reg[`CDR_CTRL_FREQ], ctrl_reg[`CDR_CTRL_SRC],
                                  ctrl_reg[`CDR_CTRL_RATE])),
        .done_o       (cmp_done),
        .in_range_o   (cmp_in_range)
    );

    // bit source: external clock edges in bypass, else the internal strobe
    assign bit_strobe = ctrl_reg[`CDR_CTRL_BYP]
                      ? (external_recovered_clock_i & ~xclk_prev_reg)
                      : rec_bit_strobe_i;
    assign bit_val    = serial_rx_input_i;

    cdr_los_det u_los (
        .clk_i        (clk_i),
        .rst_n_i      (rst_n),
        .bit_strobe_i (bit_strobe),
        .bit_i        (bit_val),
        .los_o        (los_int)
    );

    assign loss_any = los_int | ~external_signal_loss_n_i;
    // loopback keeps data flowing even without line signal
    assign mute     = loss_any & ~ctrl_reg[`CDR_CTRL_DLPBK]
                    & ~ctrl_reg[`CDR_CTRL_ALPBK];

    // lock sequencer
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            CDR_ACQ_REF: begin
                // reference lock first, then data, only with no loss
                if (!cfg_change && cmp_done && cmp_in_range && !loss_any)
                    state_next = CDR_TRACK;
            end
            CDR_TRACK: begin
                if (cfg_change)
                    state_next = CDR_ACQ_REF;
                else if (cmp_done && !cmp_in_range)
                    state_next = CDR_ACQ_REF;
                else if (loss_any)
                    state_next = CDR_ACQ_REF;
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n)
            state_reg <= CDR_ACQ_REF;
        else
            state_reg <= state_next;
    end

    // events and framer clock source
    assign ev_w[`CDR_EV_LOCK]  = (state_reg == CDR_TRACK) && (state_next == CDR_ACQ_REF);
    assign ev_w[`CDR_EV_LOS]   = los_int & ~los_prev_reg;
    assign ev_w[`CDR_EV_TRACK] = (state_reg == CDR_ACQ_REF) && (state_next == CDR_TRACK);

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            los_prev_reg      <= 1'b0;
            xclk_prev_reg     <= 1'b0;
            state_o           <= CDR_ACQ_REF;
            rx_clk_from_ref_o <= 1'b1;
        end else begin
            los_prev_reg      <= los_int;
            xclk_prev_reg     <= external_recovered_clock_i;
            state_o           <= state_next;
            rx_clk_from_ref_o <= (state_next != CDR_TRACK)
                               & ~ctrl_reg[`CDR_CTRL_BYP];
        end
    end

    // deserialiser, msb first
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            shift_reg <= 8'h00;
            bcnt_reg  <= 3'h0;
        end else if (bit_strobe) begin
            shift_reg <= {shift_reg[6:0], bit_val};
            bcnt_reg  <= bcnt_reg + 3'h1;
        end
    end

    // parallel output, forced to zero for the whole loss unless a loopback is on
    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            rx_data_o       <= 8'h00;
            rx_data_valid_o <= 1'b0;
        end else begin
            rx_data_valid_o <= bit_strobe && bcnt_reg == 3'h7;
            if (mute)
                rx_data_o <= 8'h00;
            else if (bit_strobe && bcnt_reg == 3'h7)
                rx_data_o <= {shift_reg[6:0], bit_val};
        end
    end

    // checks
    property p_mute;
        @(posedge clk_i) disable iff (!rst_n)
        mute |=> rx_data_o == 8'h00;
    endproperty
    a_mute: assert property (p_mute) else $error("output not muted on loss");

    property p_loop;
        @(posedge clk_i) disable iff (!rst_n)
        (loss_any && !mute && bit_strobe && bcnt_reg == 3'h7)
            |=> rx_data_o == $past(shift_reg[6:0]) * 2 + $past(bit_val);
    endproperty
    a_loop: assert property (p_loop) else $error("loopback data muted");

    property p_enter;
        @(posedge clk_i) disable iff (!rst_n)
        (state_reg == CDR_ACQ_REF) ##1 (state_reg == CDR_TRACK)
            |-> $past(cmp_done && cmp_in_range && external_signal_loss_n_i && !los_int);
    endproperty
    a_enter: assert property (p_enter) else $error("tracking without conditions");

    property p_fall;
        @(posedge clk_i) disable iff (!rst_n)
        (state_reg == CDR_TRACK && cmp_done && !cmp_in_range) |=> state_reg == CDR_ACQ_REF;
    endproperty
    a_fall: assert property (p_fall) else $error("no fallback on deviation");

    property p_restart;
        @(posedge clk_i) disable iff (!rst_n)
        cfg_change |=> state_reg == CDR_ACQ_REF ##1 state_reg == CDR_ACQ_REF;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart on ref change");

    property p_refclk;
        @(posedge clk_i) disable iff (!rst_n)
        (loss_any && !ctrl_reg[`CDR_CTRL_BYP]) |=> rx_clk_from_ref_o;
    endproperty
    a_refclk: assert property (p_refclk) else $error("framer clock not on reference");

    property p_byp;
        @(posedge clk_i) disable iff (!rst_n)
        (ctrl_reg[`CDR_CTRL_BYP] && $rose(external_recovered_clock_i))
            |=> shift_reg[0] == $past(serial_rx_input_i);
    endproperty
    a_byp: assert property (p_byp) else $error("bypass bit not sampled");

    property p_wait;
        @(posedge clk_i) disable iff (!rst_n)
        (addr_ph && !pend_reg) |=> !hreadyout_o ##1 hreadyout_o;
    endproperty
    a_wait: assert property (p_wait) else $error("bus answer not one wait state");

    property p_irq;
        @(posedge clk_i) disable iff (!rst_n)
        (rd_int && ev_w == '0) |=> int_stat_reg == '0 && !irq_o;
    endproperty
    a_irq: assert property (p_irq) else $error("status not cleared by read");

    c_track: cover property (@(posedge clk_i) disable iff (!rst_n) ev_w[`CDR_EV_TRACK]);
    c_lost:  cover property (@(posedge clk_i) disable iff (!rst_n) ev_w[`CDR_EV_LOCK]);
    c_mute:  cover property (@(posedge clk_i) disable iff (!rst_n) mute && rx_data_valid_o);
endmodule

// File: verification/cdr_far_end.sv
`timescale 1ns/1ps
// optical module and recovery front end as seen from the control block
module cdr_far_end (
    input  wire logic clk_i,
    input  wire logic byp_i,
    input  wire logic gap_i,
    input  wire logic quiet_i,
    input  wire logic loss_i,
    input  wire logic rnd_i,
    output logic      strobe_o,
    output logic      serial_o,
    output logic      ext_clk_o,
    output logic      loss_n_o,
    output logic      ref_tick_o,
    output logic      rec_tick_o
);
    logic [2:0] ph = 3'h0;
    logic       nxt_ext;

    // quiet start, loss released
    initial begin
        {strobe_o, serial_o, ext_clk_o, ref_tick_o, rec_tick_o} = 5'h00;
        loss_n_o = 1'b1;
    end

    // external clock stands still outside bypass, period of 8 clk
    assign nxt_ext = byp_i & ~ph[2];

    // all lines move just after the rising edge
    always @(posedge clk_i) begin
        ph         <= ph + 3'h1;
        ref_tick_o <= ~ref_tick_o;
        rec_tick_o <= !(gap_i && ph == 3'h0);
        strobe_o   <= !byp_i && ph[0];
        ext_clk_o  <= nxt_ext;
        loss_n_o   <= !loss_i;
        // data changes far from the sample point, so setup and hold are wide
        if (quiet_i)
            serial_o <= 1'b0;
        else if (byp_i ? (ext_clk_o && !nxt_ext) : ph[0])
            serial_o <= rnd_i;
    end
endmodule

// File: verification/cdr_lock_ctrl_bench.sv
`timescale 1ns/1ps
module cdr_lock_ctrl_bench;
    import cdr_pkg::*;
    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'hE650, rd, hrdata;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0, byp = 1'b0, gap = 1'b0, quiet = 1'b0;
    logic        loss = 1'b0, rnd = 1'b0, chk_en = 1'b0, ext_q = 1'b0;
    logic        strobe, serial, ext_clk, loss_n, ref_tick, rec_tick;
    logic        hready, hresp, fsel, ssel, rsel, bsel, from_ref, valid, irq;
    logic [7:0]  sh = 8'h00, rx_data;
    logic [5:0]  ctrl = 6'h00;
    cdr_state_t  state;
    integer      mismatches = 0, checked = 0, i;

    always #4 clk_i = ~clk_i;

    cdr_far_end i_far (.clk_i(clk_i), .byp_i(byp), .gap_i(gap), .quiet_i(quiet),
        .loss_i(loss), .rnd_i(rnd), .strobe_o(strobe), .serial_o(serial),
        .ext_clk_o(ext_clk), .loss_n_o(loss_n), .ref_tick_o(ref_tick),
        .rec_tick_o(rec_tick));

    cdr_lock_ctrl i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .hsel_i(1'b1), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
        .rec_bit_strobe_i(strobe), .serial_rx_input_i(serial),
        .external_recovered_clock_i(ext_clk), .external_signal_loss_n_i(loss_n),
        .rec_clk_tick_i(rec_tick), .ref_tick_i(ref_tick), .state_o(state),
        .ref_freq_select_o(fsel), .recovery_ref_source_select_o(ssel),
        .line_rate_select_o(rsel), .recovery_bypass_o(bsel),
        .rx_clk_from_ref_o(from_ref), .rx_data_o(rx_data), .rx_data_valid_o(valid),
        .irq_o(irq));

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
        end
    endtask

    // one single word transfer, entered just after a rising edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= w;
        do @(posedge clk_i); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk_i); while (hready !== 1'b1);
        rd = hrdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check_word(rd & m, e);
    endtask

    task automatic set_ctrl(input logic [5:0] v);
        ctrl = v;
        bus(1'b1, 8'h00, {26'h0, v});
    endtask

    task automatic wait_state(input logic s);
        i = 0;
        while (state !== s && i < 40000) begin
            @(posedge clk_i);
            i++;
        end
        check_bit(state, s);
    endtask

    task automatic give_verdict();
        $display("mismatches %0d checked %0d", mismatches, checked);
        if (mismatches == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // random serial bits
    always @(posedge clk_i) rnd <= $random(seed);

    // mirror of the bits the block takes, bypass picks the clock
    always @(posedge clk_i) begin
        ext_q <= ext_clk;
        if (bsel ? (ext_clk && !ext_q) : strobe)
            sh <= {sh[6:0], serial};
    end

    // byte and mute monitor, off around mode changes
    always @(negedge clk_i) begin
        if (chk_en && loss && ctrl[5:4] == 2'b00)
            check_word({24'h0, rx_data}, 32'h0);
        else if (chk_en && valid)
            check_word({24'h0, rx_data}, {24'h0, sh});
    end

    // hang guard, above the whole run with both lock waits
    initial begin
        repeat (90000) @(posedge clk_i);
        mismatches++;
        give_verdict();
    end

    initial begin
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd_chk(8'h04, 32'h1, 32'h0);
        check_bit(from_ref, 1'b1);
        bus(1'b1, 8'h10, 32'hFFFFFFFF);
        rd_chk(8'h10, 32'hFFFFFFFF, 32'h0);
        check_bit(hresp, 1'b0);
        for (i = 0; i < 6; i++) begin
            rd = $random(seed);
            set_ctrl(rd[5:0]);
            rd_chk(8'h00, 32'hFFFFFFFF, {26'h0, ctrl});
            check_word({28'h0, bsel, rsel, ssel, fsel}, {28'h0, ctrl[3:0]});
        end
        set_ctrl(6'h00);
        wait_state(1'b1);
        check_bit(from_ref, 1'b0);
        chk_en = 1'b1;
        // tracking event: unmask, mask, read clears
        bus(1'b1, 8'h0C, 32'h4);
        repeat (2) @(posedge clk_i);
        check_bit(irq, 1'b1);
        bus(1'b1, 8'h0C, 32'h0);
        repeat (2) @(posedge clk_i);
        check_bit(irq, 1'b0);
        rd_chk(8'h08, 32'h4, 32'h4);
        rd_chk(8'h08, 32'h7, 32'h0);
        bus(1'b1, 8'h0C, 32'h1);
        // external loss while tracking
        chk_en = 1'b0;
        loss <= 1'b1;
        repeat (6) @(posedge clk_i);
        chk_en = 1'b1;
        check_bit(state, 1'b0);
        check_bit(from_ref, 1'b1);
        check_bit(irq, 1'b1);
        rd_chk(8'h04, 32'hF, 32'hA);
        rd_chk(8'h08, 32'h1, 32'h1);
        check_bit(irq, 1'b0);
        repeat (100) @(posedge clk_i);
        for (i = 4; i < 6; i++) begin
            chk_en = 1'b0;
            set_ctrl(i == 4 ? 6'h10 : 6'h20);
            repeat (4) @(posedge clk_i);
            chk_en = 1'b1;
            repeat (100) @(posedge clk_i);
        end
        chk_en = 1'b0;
        set_ctrl(6'h00);
        loss <= 1'b0;
        gap <= 1'b1;
        // quiet line: internal loss after more than 128 bits
        quiet <= 1'b1;
        repeat (200) @(posedge clk_i);
        rd_chk(8'h04, 32'h4, 32'h0);
        repeat (100) @(posedge clk_i);
        rd_chk(8'h04, 32'h4, 32'h4);
        check_word({24'h0, rx_data}, 32'h0);
        rd_chk(8'h08, 32'h2, 32'h2);
        quiet <= 1'b0;
        repeat (400) @(posedge clk_i);
        rd_chk(8'h04, 32'h4, 32'h0);
        chk_en = 1'b1;
        repeat (20000) @(posedge clk_i);
        check_bit(state, 1'b0);
        gap <= 1'b0;
        set_ctrl(6'h03);
        wait_state(1'b1);
        set_ctrl(6'h02);
        repeat (4) @(posedge clk_i);
        check_bit(state, 1'b1);
        set_ctrl(6'h00);
        repeat (2) @(posedge clk_i);
        check_bit(state, 1'b0);
        chk_en = 1'b0;
        byp <= 1'b1;
        set_ctrl(6'h08);
        // let ten bypass bits flush any bit taken while the mirror lagged
        repeat (80) @(posedge clk_i);
        chk_en = 1'b1;
        check_bit(from_ref, 1'b0);
        repeat (400) @(posedge clk_i);
        give_verdict();
    end
endmodule
